// ---- clock_fanout_select_enable.sv ----
// ============================================================================
// Purpose: Control logic of an eight-output clock fanout buffer: input
//          selection, per-bank output disable and a reference output whose
//          enable is resynchronized to the selected input clock.
// Assumes: Clock pins are sampled on core_clk, which runs well above the
//          input clocks, so each input cycle spans many core cycles.
// Notes:   Software sets the straps through the control register; the status
//          register shows what the block is actually doing.
//
// How it works
// - Select 00 routes universal input 0, 01 universal input 1, 1x the crystal.
// - The crystal oscillator stays powered down while a universal input is chosen.
// - Choosing the crystal starts the oscillator and its clock reaches every output.
// - With the crystal chosen, enabled outputs carry the inverse of its level.
// - Universal inputs pass their level; floating or shorted pairs give a low output.
// - Each bank drives when its disable bit is 0, high impedance when 1.
// - The reference output carries a copy of the selected input clock.
// - The reference output is high impedance with enable 0, driving with enable 1.
// - The reference enable is resynchronized to the selected clock, avoiding runts.
// - Reference output starts driving within 3 selected clock cycles of enable rising.
// - Reference output goes high impedance within 3 cycles of enable falling.
// ============================================================================
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

module clock_fanout_select_enable #(
   parameter int unsigned BANK_WIDTH = clock_fanout_pkg::BANK_WIDTH
) (
   // Clock and reset.
   input  wire logic                                   core_clk,
   input  wire logic                                   rst,
   // Avalon-MM register slave.
   input  wire logic [clock_fanout_pkg::ADDR_W-1:0]    avs_address,
   input  wire logic                                   avs_read,
   input  wire logic                                   avs_write,
   input  wire logic [clock_fanout_pkg::DATA_W-1:0]    avs_writedata,
   input  wire logic [clock_fanout_pkg::BYTE_EN_W-1:0] avs_byteenable,
   output logic      [clock_fanout_pkg::DATA_W-1:0]    avs_readdata,
   output logic                                        avs_waitrequest,
   // Clock input pins: universal pairs true and complement, crystal single-ended.
   input  wire logic                                   universal_input_0,
   input  wire logic                                   universal_input_0_n,
   input  wire logic                                   universal_input_1,
   input  wire logic                                   universal_input_1_n,
   input  wire logic                                   crystal_input,
   // Crystal oscillator power control.
   output logic                                        osc_enable,
   // Differential bank A.
   output logic      [BANK_WIDTH-1:0]                  bank_a_out,
   output logic      [BANK_WIDTH-1:0]                  bank_a_out_n,
   output logic      [BANK_WIDTH-1:0]                  bank_a_oe,
   // Differential bank B.
   output logic      [BANK_WIDTH-1:0]                  bank_b_out,
   output logic      [BANK_WIDTH-1:0]                  bank_b_out_n,
   output logic      [BANK_WIDTH-1:0]                  bank_b_oe,
   // Single-ended reference output.
   output logic                                        ref_clock_output,
   output logic                                        ref_clock_output_oe
);

   // =========================================================================
   // Helper functions
   // =========================================================================

   // A universal pair reads high only when the true pin is high and the
   // complement low; a floating or shorted pair shows equal levels and reads
   // low.
   function automatic logic univ_level(input logic true_pin, input logic comp_pin);
      univ_level = true_pin & ~comp_pin;
   endfunction : univ_level

   // =========================================================================
   // Declarations
   // =========================================================================
   localparam int unsigned NPINS = 5;

   logic [NPINS-1:0]                    pin_meta_q;
   logic [NPINS-1:0]                    pin_sync_q;
   logic [1:0]                          sel_q;
   logic                                bank_a_dis_q;
   logic                                bank_b_dis_q;
   logic                                ref_en_q;
   clock_fanout_pkg::bus_state_t        bus_state_q;
   clock_fanout_pkg::bus_state_t        bus_state_d;
   logic                                level_q;
   logic                                level_prev_q;
   logic                                en_stage1_q;
   logic                                en_stage2_q;
   logic                                osc_enable_q;
   logic [BANK_WIDTH-1:0]               bank_a_out_q;
   logic [BANK_WIDTH-1:0]               bank_a_out_n_q;
   logic [BANK_WIDTH-1:0]               bank_a_oe_q;
   logic [BANK_WIDTH-1:0]               bank_b_out_q;
   logic [BANK_WIDTH-1:0]               bank_b_out_n_q;
   logic [BANK_WIDTH-1:0]               bank_b_oe_q;
   logic                                ref_out_q;
   logic                                ref_oe_q;
   logic [clock_fanout_pkg::DATA_W-1:0] readdata_q;
   logic [clock_fanout_pkg::DATA_W-1:0] readdata_d;
   logic                                waitrequest_q;

   wire logic                           u0_p_s;
   wire logic                           u0_n_s;
   wire logic                           u1_p_s;
   wire logic                           u1_n_s;
   wire logic                           xtal_s;
   wire logic                           xtal_chosen;
   wire logic                           xtal_level;
   wire logic                           level_d;
   wire logic                           sel_rise;
   wire logic                           sel_fall;
   wire logic                           bus_req;
   wire logic                           bus_take;
   wire logic                           hit_ctrl;
   wire logic                           hit_status;
   wire logic                           ctrl_wr;
   wire logic [clock_fanout_pkg::DATA_W-1:0] ctrl_word;
   wire logic [clock_fanout_pkg::DATA_W-1:0] status_word;

   // =========================================================================
   // Pin synchronizers
   // =========================================================================

   // Every clock pin comes from outside core_clk, so each passes two flops.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end
      else
      begin
         pin_meta_q <= {crystal_input, universal_input_1_n, universal_input_1,
                        universal_input_0_n, universal_input_0};
         pin_sync_q <= pin_meta_q;
      end
   end

   // Named views of the synchronized pins.
   assign u0_p_s = pin_sync_q[0];
   assign u0_n_s = pin_sync_q[1];
   assign u1_p_s = pin_sync_q[2];
   assign u1_n_s = pin_sync_q[3];
   assign xtal_s = pin_sync_q[4];

   // =========================================================================
   // Input selection
   // =========================================================================

   // The high select bit alone picks the crystal; the low bit is then ignored.
   assign xtal_chosen = sel_q[clock_fanout_pkg::SEL_XTAL_BIT];

   // A powered-down oscillator gives no clock, so its level counts only while
   // the oscillator runs.
   assign xtal_level = osc_enable_q & xtal_s;

   // Selected level: crystal inverted, else the chosen universal pair.
   assign level_d = xtal_chosen ? ~xtal_level :
                    (sel_q == clock_fanout_pkg::SEL_UNIV_1) ?
                       univ_level(u1_p_s, u1_n_s) :
                       univ_level(u0_p_s, u0_n_s);

   // Edges of the selected clock, seen after the registered level.
   assign sel_rise = level_q & ~level_prev_q;
   assign sel_fall = ~level_q & level_prev_q;

   // =========================================================================
   // Register bus decode
   // =========================================================================

   // A request is taken in idle; the answer cycle drops waitrequest.
   assign bus_req    = avs_read | avs_write;
   assign bus_take   = (bus_state_q == clock_fanout_pkg::BUS_IDLE) & bus_req;
   assign hit_ctrl   = (avs_address == clock_fanout_pkg::CTRL_OFFSET);
   assign hit_status = (avs_address == clock_fanout_pkg::STATUS_OFFSET);

   // A write lands on the edge where the master sees waitrequest low.
   assign ctrl_wr = (bus_state_q == clock_fanout_pkg::BUS_ANSWER) & avs_write & hit_ctrl &
                    avs_byteenable[clock_fanout_pkg::CTRL_BYTE_LANE];

   // Control word as software wrote it, unused bits zero.
   assign ctrl_word = clock_fanout_pkg::DATA_W'(
                         {ref_en_q, bank_b_dis_q, bank_a_dis_q, sel_q});

   // Status word shows the live state of the block, unused bits zero.
   assign status_word = clock_fanout_pkg::DATA_W'(
                           {~bank_b_dis_q, ~bank_a_dis_q, level_q, ref_oe_q,
                            osc_enable_q});

   // Read mux; unmapped addresses read zero.
   always_comb
   begin
      if (avs_read & hit_ctrl)
      begin
         readdata_d = ctrl_word;
      end
      else if (avs_read & hit_status)
      begin
         readdata_d = status_word;
      end
      else
      begin
         readdata_d = '0;
      end
   end

   // Answer sequencer: one wait cycle, then one answer cycle.
   always_comb
   begin
      bus_state_d = bus_state_q;
      case (bus_state_q)
         clock_fanout_pkg::BUS_IDLE:
         begin
            if (bus_req)
            begin
               bus_state_d = clock_fanout_pkg::BUS_ANSWER;
            end
         end
         clock_fanout_pkg::BUS_ANSWER:
         begin
            bus_state_d = clock_fanout_pkg::BUS_IDLE;
         end
         default:
         begin
            bus_state_d = clock_fanout_pkg::BUS_IDLE;
         end
      endcase
   end

   // Bus state, waitrequest and read data registers.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         bus_state_q   <= clock_fanout_pkg::BUS_IDLE;
         waitrequest_q <= 1'h1;
         readdata_q    <= '0;
      end
      else
      begin
         bus_state_q   <= bus_state_d;
         waitrequest_q <= ~bus_take;
         readdata_q    <= bus_take ? readdata_d : readdata_q;
      end
   end

   // =========================================================================
   // Control register
   // =========================================================================

   // Select, bank disables and reference enable, written by software.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sel_q        <= clock_fanout_pkg::SEL_RESET;
         bank_a_dis_q <= clock_fanout_pkg::BANK_DIS_RESET;
         bank_b_dis_q <= clock_fanout_pkg::BANK_DIS_RESET;
         ref_en_q     <= clock_fanout_pkg::REF_EN_RESET;
      end
      else if (ctrl_wr)
      begin
         sel_q        <= avs_writedata[clock_fanout_pkg::SEL_MSB:clock_fanout_pkg::SEL_LSB];
         bank_a_dis_q <= avs_writedata[clock_fanout_pkg::BANK_A_DIS_BIT];
         bank_b_dis_q <= avs_writedata[clock_fanout_pkg::BANK_B_DIS_BIT];
         ref_en_q     <= avs_writedata[clock_fanout_pkg::REF_EN_BIT];
      end
   end

   // =========================================================================
   // Oscillator power
   // =========================================================================

   // The oscillator runs only while the crystal is selected.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         osc_enable_q <= 1'h0;
      end
      else
      begin
         osc_enable_q <= xtal_chosen;
      end
   end

   // =========================================================================
   // Selected clock level
   // =========================================================================

   // Register the selected level and keep the previous one for edge finding.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         level_q      <= 1'h0;
         level_prev_q <= 1'h0;
      end
      else
      begin
         level_q      <= level_d;
         level_prev_q <= level_q;
      end
   end

   // =========================================================================
   // Differential banks
   // =========================================================================

   // Both banks carry the selected clock; each disable bit releases its pins.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         bank_a_out_q   <= '0;
         bank_a_out_n_q <= '0;
         bank_a_oe_q    <= '0;
         bank_b_out_q   <= '0;
         bank_b_out_n_q <= '0;
         bank_b_oe_q    <= '0;
      end
      else
      begin
         bank_a_out_q   <= {BANK_WIDTH{level_q}};
         bank_a_out_n_q <= {BANK_WIDTH{~level_q}};
         bank_a_oe_q    <= {BANK_WIDTH{~bank_a_dis_q}};
         bank_b_out_q   <= {BANK_WIDTH{level_q}};
         bank_b_out_n_q <= {BANK_WIDTH{~level_q}};
         bank_b_oe_q    <= {BANK_WIDTH{~bank_b_dis_q}};
      end
   end

   // =========================================================================
   // Reference output
   // =========================================================================

   // The enable steps through two stages on rising edges of the selected
   // clock, then takes effect on the following falling edge, when the output
   // is low, so neither turn-on nor turn-off can clip a high pulse.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         en_stage1_q <= 1'h0;
         en_stage2_q <= 1'h0;
         ref_oe_q    <= 1'h0;
      end
      else
      begin
         if (sel_rise)
         begin
            en_stage1_q <= ref_en_q;
            en_stage2_q <= en_stage1_q;
         end
         if (sel_fall)
         begin
            ref_oe_q <= en_stage2_q;
         end
      end
   end

   // The reference output copies the selected level in step with its enable.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ref_out_q <= 1'h0;
      end
      else
      begin
         ref_out_q <= level_q;
      end
   end

   // =========================================================================
   // Output ports
   // =========================================================================

   // All outputs come straight from flops.
   assign avs_readdata        = readdata_q;
   assign avs_waitrequest     = waitrequest_q;
   assign osc_enable          = osc_enable_q;
   assign bank_a_out          = bank_a_out_q;
   assign bank_a_out_n        = bank_a_out_n_q;
   assign bank_a_oe           = bank_a_oe_q;
   assign bank_b_out          = bank_b_out_q;
   assign bank_b_out_n        = bank_b_out_n_q;
   assign bank_b_oe           = bank_b_oe_q;
   assign ref_clock_output    = ref_out_q;
   assign ref_clock_output_oe = ref_oe_q;

endmodule : clock_fanout_select_enable

// ---- clock_fanout_pkg.sv ----
// ============================================================================
// Purpose: Shared constants and types for the clock fanout select and enable
//          logic.
// Assumes: Registers are reached over a 32-bit Avalon-MM slave with byte
//          addressing on a four-bit address.
// Notes:   Every offset, field position, reset value and width lives here.
// ============================================================================
package clock_fanout_pkg;

   // =========================================================================
   // Bus geometry
   // =========================================================================
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned ADDR_W     = 4;
   localparam int unsigned BYTE_EN_W  = 4;
   localparam int unsigned BANK_WIDTH = 4;

   // =========================================================================
   // Register offsets, byte addresses
   // =========================================================================
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;

   // =========================================================================
   // Control register fields
   // =========================================================================
   localparam int unsigned SEL_LSB        = 0;
   localparam int unsigned SEL_MSB        = 1;
   localparam int unsigned BANK_A_DIS_BIT = 2;
   localparam int unsigned BANK_B_DIS_BIT = 3;
   localparam int unsigned REF_EN_BIT     = 4;
   localparam int unsigned CTRL_BYTE_LANE = 0;

   // Reset values of the control fields.
   localparam logic [1:0] SEL_RESET      = 2'h0;
   localparam logic       BANK_DIS_RESET = 1'h1;
   localparam logic       REF_EN_RESET   = 1'h0;

   // =========================================================================
   // Status register fields
   // =========================================================================
   localparam int unsigned ST_OSC_RUN_BIT   = 0;
   localparam int unsigned ST_REF_DRIVE_BIT = 1;
   localparam int unsigned ST_LEVEL_BIT     = 2;
   localparam int unsigned ST_BANK_A_BIT    = 3;
   localparam int unsigned ST_BANK_B_BIT    = 4;

   // =========================================================================
   // Input selection codes
   // =========================================================================
   localparam logic [1:0] SEL_UNIV_0   = 2'h0;
   localparam logic [1:0] SEL_UNIV_1   = 2'h1;
   localparam int unsigned SEL_XTAL_BIT = 1;

   // Bus answer sequencer states.
   typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage : clock_fanout_pkg

// ---- clock_fanout_props.sv ----
// Purpose: Concurrent checks on the clock fanout select and enable block.
// Assumes: Bound to the top module; one clock domain with an active high reset.
// Notes:   A control write lands at the edge where waitrequest is sampled low.
`timescale 1ns/1ps
// ============================================================================
// Checker
module clock_fanout_props #(
   parameter int unsigned BANK_WIDTH = 4
) (
   // Clock and reset.
   input wire logic                  core_clk,
   input wire logic                  rst,
   // Register bus.
   input wire logic [3:0]            avs_address,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic [31:0]           avs_writedata,
   input wire logic [3:0]            avs_byteenable,
   input wire logic [31:0]           avs_readdata,
   input wire logic                  avs_waitrequest,
   // Clock outputs.
   input wire logic                  osc_enable,
   input wire logic [BANK_WIDTH-1:0] bank_a_out,
   input wire logic [BANK_WIDTH-1:0] bank_a_out_n,
   input wire logic [BANK_WIDTH-1:0] bank_a_oe,
   input wire logic [BANK_WIDTH-1:0] bank_b_oe,
   input wire logic                  ref_clock_output,
   input wire logic                  ref_clock_output_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Landing of a control write and the answer edge of a read.
   wire ctl_wr = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
   wire ans_rd = avs_read && !avs_waitrequest;
   // The slave answers after exactly one wait cycle and for one cycle only.
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("late bus answer");
   wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer too long");
   osc_sel_a: assert property (ctl_wr |-> ##2 osc_enable == $past(avs_writedata[1], 2))
      else $error("oscillator power wrong");
   bank_a_a: assert property (ctl_wr |-> ##2
      bank_a_oe == {BANK_WIDTH{!$past(avs_writedata[2], 2)}}) else $error("bank A drive wrong");
   bank_b_a: assert property (ctl_wr |-> ##2
      bank_b_oe == {BANK_WIDTH{!$past(avs_writedata[3], 2)}}) else $error("bank B drive wrong");
   unmapped_zero_a: assert property (ans_rd && avs_address != 4'h0 && avs_address != 4'h4
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   status_bits_a: assert property (ans_rd && avs_address == 4'h4 |->
      avs_readdata[0] == osc_enable && avs_readdata[3] == bank_a_oe[0]
      && avs_readdata[4] == bank_b_oe[0]) else $error("status bits wrong");
   ref_glitch_a: assert property ($changed(ref_clock_output_oe) |-> $fell(ref_clock_output))
      else $error("reference drive glitch");
   ref_copy_a: assert property (ref_clock_output_oe && bank_a_oe[0] |->
      ref_clock_output == bank_a_out[0]) else $error("reference copy wrong");
   bank_diff_a: assert property (bank_a_oe[0] |-> bank_a_out == ~bank_a_out_n)
      else $error("bank A pair not complementary");
   // Main scenarios.
   c_xtal: cover property (osc_enable && bank_a_oe[0]);
   c_ref_on: cover property ($rose(ref_clock_output_oe));
   c_unmapped: cover property (ans_rd && avs_address == 4'h8);
endmodule : clock_fanout_props
bind clock_fanout_select_enable clock_fanout_props #(.BANK_WIDTH(BANK_WIDTH))
   i_clock_fanout_props (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .osc_enable, .bank_a_out, .bank_a_out_n,
   .bank_a_oe, .bank_b_oe, .ref_clock_output, .ref_clock_output_oe);

// ---- clock_source_model.sv ----
// Purpose: Board-side clock source feeding the block's clock input pins.
// Assumes: Runs from the bench clock; pins change just after a rising edge.
// Notes:   Static levels or free-running clocks; a shorted pair shows equal pins.
`timescale 1ns/1ps
// ============================================================================
// Clock source model
module clock_source_model (
   // Control from the bench.
   input  wire logic       core_clk,
   input  wire logic       toggle,
   input  wire logic [2:0] pin_val,
   input  wire logic       short_pair,
   // Clock pins.
   output logic            clk_pin_0,
   output logic            clk_pin_0_n,
   output logic            clk_pin_1,
   output logic            clk_pin_1_n,
   output logic            xtal_pin
);
   logic [4:0] div_q = 5'h00;
   // Free-running divider; pin periods of 16 and 32 core cycles stay slow enough to sample.
   always_ff @(posedge core_clk)
   begin
      div_q <= div_q + 5'h01;
   end
   // Pins take the bench levels unless they run free.
   assign clk_pin_0 = toggle ? div_q[3] : pin_val[0];
   assign clk_pin_1 = toggle ? div_q[4] : pin_val[1];
   assign xtal_pin = toggle ? ~div_q[4] : pin_val[2];
   // A floating or shorted pair is shown as equal levels on both pins.
   assign clk_pin_0_n = short_pair ? clk_pin_0 : ~clk_pin_0;
   assign clk_pin_1_n = short_pair ? clk_pin_1 : ~clk_pin_1;
endmodule : clock_source_model

// ---- testbench.sv ----
// Purpose: Self-checking bench for the clock fanout select and enable block.
// Assumes: Registers are reached over Avalon-MM; pins come from the source model.
// Notes:   Every wait is bounded; a hang ends in the closing report.
`timescale 1ns/1ps
// ============================================================================
// Bench
module testbench;
   logic        core_clk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
   logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic        avs_waitrequest, osc_enable, ref_clock_output, ref_clock_output_oe, e, prev;
   logic        toggle = 1'h0, short_pair = 1'h0, u0, u0_n, u1, u1_n, xt;
   logic [2:0]  pin_val = 3'h0;
   logic [3:0]  bank_a_out, bank_a_out_n, bank_a_oe, bank_b_out, bank_b_out_n, bank_b_oe;
   int          n_fail = 0, checks_done = 0, n;
   // Clock of 5 ns.
   always #2.5 core_clk = ~core_clk;
   clock_fanout_select_enable i_clock_fanout_select_enable (.core_clk, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .universal_input_0(u0), .universal_input_0_n(u0_n), .universal_input_1(u1),
      .universal_input_1_n(u1_n), .crystal_input(xt), .osc_enable, .bank_a_out, .bank_a_out_n,
      .bank_a_oe, .bank_b_out, .bank_b_out_n, .bank_b_oe, .ref_clock_output, .ref_clock_output_oe);
   clock_source_model i_clock_source_model (.core_clk, .toggle, .pin_val, .short_pair,
      .clk_pin_0(u0), .clk_pin_0_n(u0_n), .clk_pin_1(u1), .clk_pin_1_n(u1_n), .xtal_pin(xt));
   // Compares one value and counts the outcome.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // One bus transfer held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (avs_waitrequest !== 1'h0 && k < 20);
      if (avs_waitrequest !== 1'h0)
      begin
         n_fail++;
         give_verdict();
      end
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask : bus
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   // Main sequence.
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      @(negedge core_clk);
      check("reset oe", {osc_enable, bank_a_oe, bank_b_oe, ref_clock_output_oe}, 32'h0);
      bus(1'h0, 4'h0, 32'h0);
      check("control reset", q, 32'h0000000C);
      bus(1'h1, 4'h8, 32'hFFFFFFFF);
      bus(1'h1, 4'h4, 32'h0000001F);
      avs_byteenable <= 4'h0;
      bus(1'h1, 4'h0, 32'h00000000);
      avs_byteenable <= 4'hF;
      bus(1'h0, 4'h8, 32'h0);
      check("unmapped read", q, 32'h0);
      bus(1'h0, 4'h0, 32'h0);
      check("control kept", q, 32'h0000000C);
      // Every select code against every pin pattern.
      for (int s = 0; s < 4; s++)
      begin
         bus(1'h1, 4'h0, 32'(s));
         for (int v = 0; v < 16; v++)
         begin
            @(posedge core_clk);
            pin_val <= v[2:0];
            short_pair <= v[3];
            repeat (8) @(posedge core_clk);
            @(negedge core_clk);
            e = (s == 0) ? v[0] & !v[3] : (s == 1) ? v[1] & !v[3] : !v[2];
            check("bank a level", bank_a_out, {4{e}});
            check("bank b pair", {bank_b_out, bank_b_out_n}, {{4{e}}, {4{!e}}});
            check("ref level", ref_clock_output, e);
         end
         check("osc power", osc_enable, s[1]);
      end
      // Each bank disable combination.
      for (int b = 0; b < 4; b++)
      begin
         bus(1'h1, 4'h0, 32'(b) << 2);
         bus(1'h0, 4'h4, 32'h0);
         check("status banks", q, {27'h0, !b[1], !b[0], 3'h0});
         check("bank a drive", bank_a_oe, {4{!b[0]}});
         check("bank b drive", bank_b_oe, {4{!b[1]}});
      end
      // Reference enable and disable with running clocks on whole pairs.
      toggle <= 1'h1;
      short_pair <= 1'h0;
      for (int en = 1; en >= 0; en--)
      begin
         bus(1'h1, 4'h0, 32'(en) << 4);
         n = 0;
         prev = u0;
         for (int k = 0; k < 200 && ref_clock_output_oe !== en[0]; k++)
         begin
            @(negedge core_clk);
            if (u0 && !prev)
               n++;
            prev = u0;
         end
         check("enable delay", n <= 3, 1'h1);
         check("ref drive", ref_clock_output_oe, en[0]);
      end
      give_verdict();
   end
endmodule : testbench
